// file: rtl/sfi_map.svh
// constants of the identity and secure-area command unit
`ifndef SFI_MAP_SVH
`define SFI_MAP_SVH
`define SFI_OP_MPC     8'h90
`define SFI_OP_UID     8'h4B
`define SFI_OP_QID     8'hAF
`define SFI_OP_ENTER   8'hB1
`define SFI_OP_LEAVE   8'hC1
`define SFI_OP_RSEC    8'h2B
`define SFI_OP_WSEC    8'h2F
`define SFI_OP_WPERMIT 8'h06
`define SFI_ADDR_DEV   8'h01
`define SFI_MPC_DUMMY  7'h02
`define SFI_UID_DUMMY  7'h04
`define SFI_QID_LAST   6'h02
`define SFI_SEC_RST    8'h00
`define SFI_SEC_EFAIL  6
`define SFI_SEC_PFAIL  5
`define SFI_SEC_ESUSP  3
`define SFI_SEC_PSUSP  2
`define SFI_SEC_LOCK   1
`define SFI_SPI_LAST   3'h7
`define SFI_QPI_LAST   3'h4
`endif

// file: rtl/sfi_pkg.sv
// types of the identity and secure-area command unit
package sfi_pkg;
  typedef enum logic [2:0] {
    ST_CMD   = 3'b000,
    ST_DUMMY = 3'b001,
    ST_ADDR  = 3'b010,
    ST_OUT   = 3'b011,
    ST_WDATA = 3'b100,
    ST_SKIP  = 3'b101
  } sfi_state_t;
  typedef enum logic [2:0] {
    CMD_NONE = 3'b000,
    CMD_MPC  = 3'b001,
    CMD_QID  = 3'b010,
    CMD_UID  = 3'b011,
    CMD_RSEC = 3'b100
  } sfi_cmd_t;
endpackage

// file: rtl/sfi_uid_if.sv
// unique-id memory port between core and memory
`timescale 1ns/100ps
interface sfi_uid_if;
  logic [5:0] addr;
  logic [7:0] data;
  modport mem  (input addr, output data);
  modport user (output addr, input data);
endinterface

// file: rtl/sfi_uid_rom.sv
// factory-set 64-byte unique id, registered read
`timescale 1ns/100ps
module sfi_uid_rom #(
  parameter logic [511:0] UID_BYTES = {8{64'h0123_4567_89AB_CDEF}} // arbitrary value
) (
  input wire logic CLK,     // core clock
  sfi_uid_if.mem   port     // address in, data out
);
  always_ff @(posedge CLK) begin
    port.data <= UID_BYTES[{port.addr, 3'h0} +: 8];
  end
endmodule // sfi_uid_rom

// file: rtl/sfi_core.sv
// identity reads, secure area mode and security byte over the serial link
//
// Operation
// - 90h read: opcode, two dummy bytes, one address byte, then id bytes.
// - id bytes leave on falling clock edges, most significant bit first.
// - address 01h: device id first, then manufacturer id.
// - ids alternate while clocks continue; chip select high ends it.
// - quad id read outputs manufacturer, type, density on falling edges.
// - quad id output runs until chip select rises.
// - enter command puts device into secure-area mode for reads and programs.
// - leave command returns device to main-array operation.
// - main array blocked while in secure-area mode.
// - commands take 8 single-line or 2 quad clocks; upper lines ignored single.
// - security byte readable any time, repeated while clocks continue.
// - security write changes only bit 1 lock, which never clears.
// - lock set refuses all secure-area program and erase.
// - security write without byte-aligned chip select rise is discarded.
// - security byte: e-fail 6, p-fail 5, suspends 3/2, lock 1, rest zero.
// - 4Bh plus four dummy bytes returns 64-byte unique id on falling edges.
// - write permit latch cleared when a write cycle completes.
`timescale 1ns/100ps
`include "sfi_map.svh"
module sfi_core #(
  parameter logic [7:0] MFR_ID  = 8'hA5, // arbitrary value
  parameter logic [7:0] DEV_ID  = 8'h3C, // arbitrary value
  parameter logic [7:0] TYPE_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] DENS_ID = 8'hC3  // arbitrary value
) (
  input  wire logic       CLK,          // core clock
  input  wire logic       SYS_RST,      // sync reset
  input  wire logic       CS_N,         // chip select pin
  input  wire logic       SCLK,         // serial clock pin
  input  wire logic [3:0] IO_IN,        // data pins in
  output logic      [3:0] IO_OUT,       // data pins out
  output logic      [3:0] IO_OE,        // data pins drive enable
  input  wire logic       QUAD_MODE,    // quad command mode level
  input  wire logic       LOCK_NV,      // stored lock state
  input  wire logic       E_FAIL_SET,   // erase failed pulse
  input  wire logic       P_FAIL_SET,   // program failed pulse
  input  wire logic       FAIL_CLR,     // clear fail flags pulse
  input  wire logic       E_SUSP,       // erase suspended level
  input  wire logic       P_SUSP,       // program suspended level
  input  wire logic       WRITE_DONE,   // self-timed write end pulse
  output logic            SECURE_MODE,  // secure area selected
  output logic            MAIN_BLOCKED, // main array access refused
  output logic            OTP_LOCKED,   // secure area read only
  output logic            LOCK_PROG,    // program lock bit pulse
  output logic            WRITE_PERMIT, // write permit latch
  output logic      [7:0] SEC_BYTE      // security byte
);
  import sfi_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic       cs_n_m, cs_n_s, cs_n_d, ck_m, ck_s, ck_d;
  logic [3:0] io_m, io_s;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      {cs_n_d, cs_n_s, cs_n_m} <= 3'h7;
      {ck_d, ck_s, ck_m} <= 3'h0;
      io_m <= 4'h0;
      io_s <= 4'h0;
    end else begin
      {cs_n_d, cs_n_s, cs_n_m} <= {cs_n_s, cs_n_m, CS_N};
      {ck_d, ck_s, ck_m} <= {ck_s, ck_m, SCLK};
      io_m <= IO_IN;
      io_s <= io_m;
    end
  end
  logic sel, rise, fall, cs_up;
  assign sel   = ~cs_n_s;
  assign rise  = sel & ck_s & ~ck_d;
  assign fall  = sel & ~ck_s & ck_d;
  assign cs_up = cs_n_s & ~cs_n_d;

  // ----------------------------------------
  // input shifter and command decode
  // ----------------------------------------
  sfi_state_t state;
  sfi_cmd_t   cmd;
  logic [7:0] in_sr, next_in, wdata;
  logic [2:0] bit_cnt;
  logic [6:0] byte_cnt;
  logic       byte_end, got_byte, dev_first;
  assign next_in  = QUAD_MODE ? {in_sr[3:0], io_s} : {in_sr[6:0], io_s[0]};
  assign byte_end = rise & (bit_cnt == (QUAD_MODE ? `SFI_QPI_LAST : `SFI_SPI_LAST));
  logic op_take;
  assign op_take = byte_end & (state == ST_CMD);

  always_ff @(posedge CLK) begin
    if (SYS_RST || !sel) begin
      bit_cnt <= 3'h0;
      in_sr   <= 8'h00;
    end else if (rise) begin
      in_sr   <= next_in;
      bit_cnt <= byte_end ? 3'h0 : bit_cnt + (QUAD_MODE ? 3'h4 : 3'h1);
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST || !sel) begin
      state    <= ST_CMD;
      cmd      <= CMD_NONE;
      byte_cnt <= 7'h00;
      got_byte <= 1'b0;
      wdata    <= 8'h00;
    end else if (byte_end) begin
      case (state)
        ST_CMD: begin
          case (next_in)
            `SFI_OP_MPC: begin
              cmd   <= CMD_MPC;
              state <= ST_DUMMY;
            end
            `SFI_OP_UID: begin
              cmd   <= CMD_UID;
              state <= ST_DUMMY;
            end
            `SFI_OP_QID: begin
              cmd   <= CMD_QID;
              state <= ST_OUT;
            end
            `SFI_OP_RSEC: begin
              cmd   <= CMD_RSEC;
              state <= ST_OUT;
            end
            `SFI_OP_WSEC: state <= ST_WDATA;
            default:      state <= ST_SKIP;
          endcase
        end
        ST_DUMMY: begin
          byte_cnt <= byte_cnt + 7'h01;
          if (cmd == CMD_MPC && byte_cnt == `SFI_MPC_DUMMY - 7'h01)
            state <= ST_ADDR;
          else if (cmd == CMD_UID && byte_cnt == `SFI_UID_DUMMY - 7'h01)
            state <= ST_OUT;
        end
        ST_ADDR:  state <= ST_OUT;
        ST_WDATA: begin
          wdata    <= next_in;
          got_byte <= 1'b1;
        end
        default:  state <= state;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST)
      dev_first <= 1'b0;
    else if (byte_end && state == ST_ADDR)
      dev_first <= (next_in == `SFI_ADDR_DEV);
  end

  // ----------------------------------------
  // output serialiser
  // ----------------------------------------
  sfi_uid_if  uid ();
  sfi_uid_rom sfi_uid_rom_inst (.CLK(CLK), .port(uid.mem));
  logic [5:0] out_idx;
  logic [7:0] out_sr, cur_byte;
  logic [2:0] out_cnt;
  logic       load;
  assign uid.addr = out_idx;
  assign load     = fall & (state == ST_OUT) & (out_cnt == 3'h0);

  always_comb begin
    case (cmd)
      CMD_MPC:  cur_byte = (out_idx[0] ^ dev_first) ? DEV_ID : MFR_ID;
      CMD_QID:  cur_byte = (out_idx == 6'h0) ? MFR_ID : (out_idx == 6'h1) ? TYPE_ID : DENS_ID;
      CMD_UID:  cur_byte = uid.data;
      CMD_RSEC: cur_byte = SEC_BYTE;
      default:  cur_byte = 8'h00;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST || !sel) begin
      out_idx <= 6'h00;
      out_cnt <= 3'h0;
      out_sr  <= 8'h00;
      IO_OUT  <= 4'h0;
      IO_OE   <= 4'h0;
    end else if (load) begin
      // qid wraps over three bytes; others wrap at 64 or alternate on bit 0
      out_idx <= (cmd == CMD_QID && out_idx == `SFI_QID_LAST) ? 6'h00 : out_idx + 6'h01;
      out_cnt <= QUAD_MODE ? 3'h1 : 3'h7;
      out_sr  <= QUAD_MODE ? {cur_byte[3:0], 4'h0} : {cur_byte[6:0], 1'b0};
      IO_OUT  <= QUAD_MODE ? cur_byte[7:4] : {2'b00, cur_byte[7], 1'b0};
      IO_OE   <= QUAD_MODE ? 4'hF : 4'h2;
    end else if (fall && state == ST_OUT) begin
      out_cnt <= out_cnt - 3'h1;
      out_sr  <= QUAD_MODE ? {out_sr[3:0], 4'h0} : {out_sr[6:0], 1'b0};
      IO_OUT  <= QUAD_MODE ? out_sr[7:4] : {2'b00, out_sr[7], 1'b0};
    end
  end

  // ----------------------------------------
  // secure mode, write permit, security byte
  // ----------------------------------------
  logic lock, lock_loaded, wsec_ok, efail, pfail;
  // aligned means the last byte completed before chip select rose
  assign wsec_ok = cs_up & (state == ST_WDATA) & (bit_cnt == 3'h0) & got_byte & WRITE_PERMIT;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      SECURE_MODE  <= 1'b0;
      MAIN_BLOCKED <= 1'b0;
    end else if (op_take && next_in == `SFI_OP_ENTER) begin
      SECURE_MODE  <= 1'b1;
      MAIN_BLOCKED <= 1'b1;
    end else if (op_take && next_in == `SFI_OP_LEAVE) begin
      SECURE_MODE  <= 1'b0;
      MAIN_BLOCKED <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST)
      WRITE_PERMIT <= 1'b0;
    else if (op_take && next_in == `SFI_OP_WPERMIT)
      WRITE_PERMIT <= 1'b1;
    else if (wsec_ok || WRITE_DONE)
      WRITE_PERMIT <= 1'b0;
  end

  // stored lock is caught after reset release, never under reset
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      lock        <= 1'b0;
      lock_loaded <= 1'b0;
      LOCK_PROG   <= 1'b0;
    end else begin
      lock_loaded <= 1'b1;
      LOCK_PROG   <= wsec_ok & wdata[`SFI_SEC_LOCK] & ~lock;
      if (!lock_loaded)
        lock <= LOCK_NV;
      else if (wsec_ok && wdata[`SFI_SEC_LOCK])
        lock <= 1'b1;
    end
  end
  assign OTP_LOCKED = lock;

  // set wins over clear
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      efail <= 1'b0;
      pfail <= 1'b0;
    end else begin
      efail <= E_FAIL_SET | (efail & ~FAIL_CLR);
      pfail <= P_FAIL_SET | (pfail & ~FAIL_CLR);
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      SEC_BYTE <= `SFI_SEC_RST;
    end else begin
      SEC_BYTE                 <= `SFI_SEC_RST;
      SEC_BYTE[`SFI_SEC_EFAIL] <= efail;
      SEC_BYTE[`SFI_SEC_PFAIL] <= pfail;
      SEC_BYTE[`SFI_SEC_ESUSP] <= E_SUSP;
      SEC_BYTE[`SFI_SEC_PSUSP] <= P_SUSP;
      SEC_BYTE[`SFI_SEC_LOCK]  <= lock;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  AST_MPC_START: assert property (op_take && next_in == `SFI_OP_MPC |=> state == ST_DUMMY && cmd == CMD_MPC)
    else $error("maker part opcode not taken");
  AST_MSB_FIRST: assert property (load && !QUAD_MODE |=> IO_OUT[1] == $past(cur_byte[7]) && IO_OE == 4'h2)
    else $error("first bit not msb");
  AST_DEV_FIRST: assert property (byte_end && state == ST_ADDR && next_in == 8'h01 |=> dev_first)
    else $error("device id not first");
  AST_MFR_FIRST: assert property (load && cmd == CMD_MPC && out_idx[0] == dev_first |-> cur_byte == MFR_ID)
    else $error("maker part byte order wrong");
  AST_QID_WRAP: assert property (cmd == CMD_QID |-> out_idx <= `SFI_QID_LAST)
    else $error("quad id index out of range");
  AST_ENTER: assert property (op_take && next_in == `SFI_OP_ENTER |=> SECURE_MODE && MAIN_BLOCKED)
    else $error("secure mode not entered");
  AST_LEAVE: assert property (op_take && next_in == `SFI_OP_LEAVE |=> !SECURE_MODE ##0 !MAIN_BLOCKED)
    else $error("secure mode not left");
  AST_SPI_LANE: assert property (rise && !QUAD_MODE |=> in_sr == {$past(in_sr[6:0]), $past(io_s[0])})
    else $error("single line shift wrong");
  AST_RSEC_DATA: assert property (load && cmd == CMD_RSEC |=>
    out_sr == ($past(QUAD_MODE) ? {$past(SEC_BYTE[3:0]), 4'h0} : {$past(SEC_BYTE[6:0]), 1'b0}))
    else $error("security byte not sent");
  AST_LOCK_STICKY: assert property (lock && lock_loaded |=> lock)
    else $error("lock bit cleared");
  AST_UNALIGNED: assert property (cs_up && state == ST_WDATA && bit_cnt != 3'h0 && lock_loaded |=> lock == $past(lock))
    else $error("unaligned write took effect");
  AST_RESERVED: assert property (SEC_BYTE[7] == 1'b0 && SEC_BYTE[4] == 1'b0 && SEC_BYTE[0] == 1'b0)
    else $error("reserved security bit set");
  AST_UID_DUMMY: assert property (state == ST_DUMMY && cmd == CMD_UID && byte_end && byte_cnt == 7'h03 |=> state == ST_OUT)
    else $error("unique id dummy count wrong");
  AST_PERMIT_CLR: assert property (wsec_ok |=> !WRITE_PERMIT ##1 LOCK_PROG == 1'b0)
    else $error("write permit not cleared");


  // ----------------------------------------
  // lane, id order, dummy count, mode, permit and flag guards
  // ----------------------------------------
  // a level change of the mode inside a frame is not covered by the lane checks
  AST_QUAD_OE: assert property (load && QUAD_MODE |=> IO_OE == 4'hF && IO_OUT == $past(cur_byte[7:4]))
    else $error("quad nibble not driven");
  AST_QID_ORDER: assert property (load && cmd == CMD_QID && out_idx == 6'h1 |-> cur_byte == TYPE_ID)
    else $error("quad id type byte out of order");
  AST_OE_IDLE: assert property (!sel |=> IO_OE == 4'h0)
    else $error("drive enable held after deselect");
  AST_MPC_ALT: assert property (load && cmd == CMD_MPC |=> !sel || out_idx[0] != $past(out_idx[0]))
    else $error("maker part ids not alternating");
  AST_MPC_DUMMY: assert property (state == ST_DUMMY && cmd == CMD_MPC && byte_end && byte_cnt == 7'h01 |=> state == ST_ADDR)
    else $error("maker part dummy count wrong");
  AST_MAIN_FOLLOW: assert property (MAIN_BLOCKED == SECURE_MODE)
    else $error("main array block differs from secure mode");
  AST_SPI_LANES: assert property (IO_OE == 4'h2 |-> IO_OUT[3:2] == 2'b00 && IO_OUT[0] == 1'b0)
    else $error("unused lane driven in single mode");
  AST_PERMIT_SET: assert property (op_take && next_in == `SFI_OP_WPERMIT |=> WRITE_PERMIT)
    else $error("write permit not set");
  AST_NO_PERMIT: assert property (cs_up && !WRITE_PERMIT && lock_loaded |=> lock == $past(lock) && !LOCK_PROG)
    else $error("security write taken without permit");
  AST_DONE_CLR: assert property (WRITE_DONE && !(op_take && next_in == `SFI_OP_WPERMIT) |=> !WRITE_PERMIT)
    else $error("write end did not clear permit");
  AST_LOCK_PULSE: assert property (LOCK_PROG |=> !LOCK_PROG && lock)
    else $error("lock program pulse too long");
  AST_FAIL_WINS: assert property (E_FAIL_SET |=> efail)
    else $error("erase fail flag not set");
  AST_FAIL_CLR: assert property (FAIL_CLR && !P_FAIL_SET |=> !pfail)
    else $error("program fail flag not cleared");
  AST_SUSP: assert property (1'b1 |=> SEC_BYTE[`SFI_SEC_ESUSP] == $past(E_SUSP) && SEC_BYTE[`SFI_SEC_PSUSP] == $past(P_SUSP))
    else $error("suspend bits not following");

  CVR_MPC_OUT:   cover property (load && cmd == CMD_MPC && dev_first);
  CVR_QID_WRAP:  cover property (load && cmd == CMD_QID && out_idx == `SFI_QID_LAST);
  CVR_LOCK_SET:  cover property (wsec_ok && wdata[`SFI_SEC_LOCK]);
  CVR_UID_OUT:   cover property (load && cmd == CMD_UID);
  CVR_UNALIGNED: cover property (cs_up && state == ST_WDATA && bit_cnt != 3'h0);
endmodule // sfi_core

// file: tb/sfi_host_model.sv
// host-side flash controller model driving the serial link pins
`timescale 1ns/100ps
module sfi_host_model #(
  parameter int HALF = 8 // link half period in core clocks, 64 ns period
) (
  input  wire logic       CLK,    // core clock
  output logic            CS_N,   // chip select
  output logic            SCLK,   // serial clock, still outside frames
  output logic      [3:0] IO_IN,  // data toward device
  input  wire logic [3:0] IO_OUT  // data from device
);
  initial begin
    CS_N  = 1'b1;
    SCLK  = 1'b0;
    IO_IN = 4'hA;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge CLK);
  endtask

  task automatic sel();
    CS_N <= 1'b0;
    wait_clk(HALF);
  endtask

  // --------------------------------------------------------------------------
  // one byte each way: bits slots of 1 (single) or 4 (quad) lines
  // --------------------------------------------------------------------------
  task automatic xfer(input logic [7:0] tx, input logic quad, input int bits, output logic [7:0] rx);
    for (int i = 0; i < bits; i++) begin
      SCLK <= 1'b0;
      if (quad)
        IO_IN <= tx[7-4*i -: 4];
      else
        IO_IN <= {~{3{tx[7-i]}}, tx[7-i]};
      wait_clk(HALF);
      rx = quad ? {rx[3:0], IO_OUT} : {rx[6:0], IO_OUT[1]};
      SCLK <= 1'b1;
      wait_clk(HALF);
    end
  endtask

  // released lines flip so a stale value is never mistaken for data
  task automatic desel();
    SCLK <= 1'b0;
    wait_clk(HALF);
    CS_N  <= 1'b1;
    IO_IN <= ~IO_IN;
    wait_clk(HALF);
  endtask
endmodule // sfi_host_model

// file: tb/sfi_core_test.sv
// self-checking bench of the identity and secure-area command unit
`timescale 1ns/100ps
`include "sfi_map.svh"
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin mismatches++; $display("ERROR %s expected %0h seen %0h", n, e, a); end end
module sfi_core_test;
  // --------------------------------------------------------------------------
  // signals
  // --------------------------------------------------------------------------
  localparam logic [63:0] UID_PAT = 64'h0123_4567_89AB_CDEF; // arbitrary, rom default
  localparam logic [7:0]  MFR = 8'h96, DEV = 8'h69, TYP = 8'h33, DEN = 8'hCC; // arbitrary
  logic       clk = 1'b0, sys_rst = 1'b1, quad = 1'b0, lock_nv = 1'b0;
  logic       e_fail_set = 1'b0, p_fail_set = 1'b0, fail_clr = 1'b0;
  logic       e_susp = 1'b0, p_susp = 1'b0, write_done = 1'b0;
  logic       cs_n, sclk, secure_mode, main_blocked, otp_locked, lock_prog, write_permit;
  logic [3:0] io_in, io_out, io_oe;
  logic [7:0] sec_byte, rx;
  int         mismatches = 0, checks_done = 0, cycles = 0, lock_pulses = 0;

  always #2 clk = ~clk;

  sfi_core #(.MFR_ID(MFR), .DEV_ID(DEV), .TYPE_ID(TYP), .DENS_ID(DEN)) sfi_core_inst (
    .CLK(clk), .SYS_RST(sys_rst), .CS_N(cs_n), .SCLK(sclk), .IO_IN(io_in), .IO_OUT(io_out),
    .IO_OE(io_oe), .QUAD_MODE(quad), .LOCK_NV(lock_nv), .E_FAIL_SET(e_fail_set),
    .P_FAIL_SET(p_fail_set), .FAIL_CLR(fail_clr), .E_SUSP(e_susp), .P_SUSP(p_susp),
    .WRITE_DONE(write_done), .SECURE_MODE(secure_mode), .MAIN_BLOCKED(main_blocked),
    .OTP_LOCKED(otp_locked), .LOCK_PROG(lock_prog), .WRITE_PERMIT(write_permit), .SEC_BYTE(sec_byte));

  sfi_host_model sfi_host_model_inst (.CLK(clk), .CS_N(cs_n), .SCLK(sclk), .IO_IN(io_in), .IO_OUT(io_out));

  // run is about 14k cycles; ceiling leaves margin
  always @(posedge clk) begin
    cycles++;
    if (lock_prog === 1'b1) lock_pulses++;
    if (cycles == 60000) begin
      mismatches++;
      conclude();
    end
  end

  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  task automatic bt(input logic [7:0] tx);
    sfi_host_model_inst.xfer(tx, quad, quad ? 2 : 8, rx);
  endtask

  task automatic cmd(input logic [7:0] op);
    sfi_host_model_inst.sel();
    bt(op);
    sfi_host_model_inst.desel();
  endtask

  task automatic t_mpc(input logic [7:0] addr, input logic [7:0] a, input logic [7:0] b);
    sfi_host_model_inst.sel();
    bt(`SFI_OP_MPC);
    bt(8'h00);
    bt(8'h00);
    bt(addr);
    for (int i = 0; i < 4; i++) begin
      bt(8'h00);
      `CHK("maker part id", i[0] ? b : a, rx)
      `CHK("single oe", 4'h2, io_oe)
    end
    sfi_host_model_inst.desel();
  endtask

  task automatic t_uid();
    sfi_host_model_inst.sel();
    bt(`SFI_OP_UID);
    repeat (4) bt(8'h00);
    for (int i = 0; i < 66; i++) begin
      bt(8'h00);
      `CHK("uid byte", UID_PAT[8*(i%8) +: 8], rx)
    end
    sfi_host_model_inst.desel();
  endtask

  task automatic t_qid();
    quad <= 1'b1;
    @(posedge clk);
    sfi_host_model_inst.sel();
    bt(`SFI_OP_QID);
    for (int i = 0; i < 5; i++) begin
      bt(8'h00);
      `CHK("quad id", (i % 3 == 0) ? MFR : (i % 3 == 1) ? TYP : DEN, rx)
      `CHK("quad oe", 4'hF, io_oe)
    end
    sfi_host_model_inst.desel();
    quad <= 1'b0;
    @(posedge clk);
  endtask

  task automatic t_mode();
    cmd(`SFI_OP_ENTER);
    `CHK("secure entered", 2'b11, {secure_mode, main_blocked})
    quad <= 1'b1;
    @(posedge clk);
    cmd(`SFI_OP_LEAVE);
    `CHK("secure left", 2'b00, {secure_mode, main_blocked})
    quad <= 1'b0;
    @(posedge clk);
  endtask

  task automatic t_wsec(input logic pm, input logic [7:0] d, input int n, input logic lk, input int np);
    if (pm) cmd(`SFI_OP_WPERMIT);
    sfi_host_model_inst.sel();
    bt(`SFI_OP_WSEC);
    sfi_host_model_inst.xfer(d, quad, n, rx);
    sfi_host_model_inst.desel();
    repeat (8) @(posedge clk);
    `CHK("sec byte", {6'h00, lk, 1'b0}, sec_byte)
    `CHK("otp locked", lk, otp_locked)
    `CHK("lock pulses", np, lock_pulses)
  endtask

  task automatic t_flags();
    e_fail_set <= 1'b1;
    p_fail_set <= 1'b1;
    e_susp     <= 1'b1;
    p_susp     <= 1'b1;
    @(posedge clk);
    e_fail_set <= 1'b0;
    p_fail_set <= 1'b0;
    sfi_host_model_inst.sel();
    bt(`SFI_OP_RSEC);
    repeat (2) begin
      bt(8'h00);
      `CHK("sec read", 8'h6E, rx)
    end
    sfi_host_model_inst.desel();
    e_fail_set <= 1'b1;
    fail_clr   <= 1'b1;
    e_susp     <= 1'b0;
    @(posedge clk);
    e_fail_set <= 1'b0;
    fail_clr   <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("sec cleared", 8'h46, sec_byte)
  endtask

  task automatic t_permit();
    cmd(`SFI_OP_WPERMIT);
    `CHK("permit set", 1'b1, write_permit)
    write_done <= 1'b1;
    @(posedge clk);
    write_done <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("permit cleared", 1'b0, write_permit)
  endtask

  task automatic conclude();
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK("reset sec byte", 8'h00, sec_byte)
    t_mpc(8'h00, MFR, DEV);
    t_mpc(`SFI_ADDR_DEV, DEV, MFR);
    t_uid();
    t_qid();
    t_mode();
    t_wsec(1'b0, 8'hFF, 8, 1'b0, 0);
    t_wsec(1'b1, 8'hFF, 3, 1'b0, 0);
    t_wsec(1'b1, 8'hFF, 8, 1'b1, 1);
    `CHK("permit after write", 1'b0, write_permit)
    t_wsec(1'b1, 8'h00, 8, 1'b1, 1);
    t_flags();
    t_permit();
    lock_nv <= 1'b1;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("lock reload", 8'h06, sec_byte)
    conclude();
  end
endmodule // sfi_core_test
